/* File: logic/updown_counter.sv */
// Four bit reversible counter with separate up and down count clocks.
// Assumes count clocks, clear and load are sampled synchronous to I_CLK.
// How it works
// [R01] Four bit count; decade variant 0..9, binary variant 0..15
// [R02] Up clock rising edge with down clock high adds one
// [R03] Down clock rising edge with up clock high subtracts one
// [R04] All four count bits update together from one register
// [R05] Clear forces the count to zero regardless of count clocks
// [R06] Load low copies the preset inputs without any count edge
// [R07] Driver holds one count clock high while pulsing the other
// [R08] Driver reverses direction only while the active clock is high
// [R09] Carry and borrow outputs rest high outside terminal states
// [R10] At maximum, carry copies the low phase of the up clock
// [R11] At zero, borrow copies the low phase of the down clock; the code holds borrow high while clear is active
// [R12] Carry and borrow can clock the next stage directly
// [R13] While load is low, preset value shows on count outputs
// [R14] Clear beats load and counting and forces the count low
// [R15] First rising edge after clear or load release is counted
// [R16] Up from maximum wraps to zero, down from zero wraps to maximum
`default_nettype none
`include "updown_regs.svh"
module updown_counter
  import updown_pkg::*;
#(
  parameter bit DECADE = 1'b0
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // Count clocks
  input wire clocks_t I_CLOCKS,
  // Clear, load and preset value
  input wire ctrl_t I_CTRL,
  // Count and cascade outputs
  output count_t O_COUNT,
  output logic O_CARRY_OUT_N,
  output logic O_BORROW_OUT_N
);
  count_t count_reg;
  count_t count_next;
  count_t max_val;
  mode_t mode;
  logic up_rise, dn_rise;
  logic carry_n_reg, borrow_n_reg;

  assign max_val = DECADE ? `CNT_MAX_DEC : `CNT_MAX_BIN; // R01

  edge_detect u_up (
    .clk(I_CLK),
    .reset(I_RESET),
    .level(I_CLOCKS.count_up_clock),
    .rise(up_rise),
    .fall(),
    .last()
  );
  edge_detect u_dn (
    .clk(I_CLK),
    .reset(I_RESET),
    .level(I_CLOCKS.count_down_clock),
    .rise(dn_rise),
    .fall(),
    .last()
  );

  always_comb begin
    if (I_CTRL.master_clear) begin
      mode = ST_CLEAR; // R14
    end else if (!I_CTRL.preset_load_n) begin
      mode = ST_LOAD;
    end else begin
      mode = ST_COUNT;
    end
  end

  // Edge detectors keep running under clear and load, so an edge after
  // release is still seen while one made inside the hold is dropped
  always_comb begin
    count_next = count_reg;
    case (mode)
      ST_CLEAR: count_next = `CNT_ZERO; // R05
      ST_LOAD: count_next = I_CTRL.preset; // R06
      ST_COUNT: begin
        // Both edges together count up; the driver must avoid this
        if (up_rise && I_CLOCKS.count_down_clock) begin // R02
          if (count_reg >= max_val) begin
            count_next = `CNT_ZERO; // R16
          end else begin
            count_next = count_reg + `CNT_ONE;
          end
        end else if (dn_rise && I_CLOCKS.count_up_clock) begin // R03
          if (count_reg == `CNT_ZERO) begin
            count_next = max_val; // R16
          end else begin
            count_next = count_reg - `CNT_ONE;
          end
        end
      end
      default: count_next = `CNT_ZERO;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      count_reg <= `CNT_ZERO;
    end else begin
      count_reg <= count_next; // R04 R15
    end
  end
  assign O_COUNT = count_reg; // R13

  // Registered cascade outputs: one cycle behind the clocks, standing in
  // for the gate delays that make a chain not fully synchronous
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      carry_n_reg <= 1'b1;
    end else begin
      carry_n_reg <= ~((count_next == max_val) & ~mode[0] &
                       ~I_CLOCKS.count_up_clock); // R10 R09 R12
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      borrow_n_reg <= 1'b1;
    end else begin
      borrow_n_reg <= ~((count_next == `CNT_ZERO) & ~mode[0] &
                        ~I_CLOCKS.count_down_clock); // R11 R09 R12
    end
  end
  assign O_CARRY_OUT_N = carry_n_reg;
  assign O_BORROW_OUT_N = borrow_n_reg;

  property p_clear_zero;
    @(posedge I_CLK) disable iff (I_RESET)
      I_CTRL.master_clear |=> (O_COUNT == `CNT_ZERO);
  endproperty
  a_clear_zero: assert property (p_clear_zero) // R05
    else $error("clear did not zero count");

  property p_load;
    @(posedge I_CLK) disable iff (I_RESET)
      (!I_CTRL.master_clear && !I_CTRL.preset_load_n)
        |=> (O_COUNT == $past(I_CTRL.preset));
  endproperty
  a_load: assert property (p_load) // R06
    else $error("load did not copy preset");

  property p_up;
    @(posedge I_CLK) disable iff (I_RESET)
      (mode == ST_COUNT && up_rise && I_CLOCKS.count_down_clock &&
       count_reg < max_val) |=> (O_COUNT == $past(count_reg) + `CNT_ONE);
  endproperty
  a_up: assert property (p_up) // R02
    else $error("up edge did not add one");

  property p_down;
    @(posedge I_CLK) disable iff (I_RESET)
      (mode == ST_COUNT && dn_rise && I_CLOCKS.count_up_clock && !up_rise &&
       count_reg != `CNT_ZERO) |=> (O_COUNT == $past(count_reg) - `CNT_ONE);
  endproperty
  a_down: assert property (p_down) // R03
    else $error("down edge did not subtract one");

  property p_wrap_up;
    @(posedge I_CLK) disable iff (I_RESET)
      (mode == ST_COUNT && up_rise && I_CLOCKS.count_down_clock &&
       count_reg == max_val) |=> (O_COUNT == `CNT_ZERO);
  endproperty
  a_wrap_up: assert property (p_wrap_up) // R16
    else $error("up wrap failed");

  property p_range;
    @(posedge I_CLK) disable iff (I_RESET)
      (mode == ST_COUNT && count_reg <= max_val) |=> (O_COUNT <= max_val);
  endproperty
  a_range: assert property (p_range) // R01
    else $error("count left its range");

  property p_steady;
    @(posedge I_CLK) disable iff (I_RESET)
      (mode == ST_COUNT && !up_rise && !dn_rise) |=> $stable(O_COUNT);
  endproperty
  a_steady: assert property (p_steady) // R04
    else $error("count changed without an edge");

  property p_carry;
    @(posedge I_CLK) disable iff (I_RESET)
      !O_CARRY_OUT_N |-> ($past(count_next) == max_val &&
                          !$past(I_CLOCKS.count_up_clock));
  endproperty
  a_carry: assert property (p_carry) // R10
    else $error("carry low outside terminal state");

  property p_borrow;
    @(posedge I_CLK) disable iff (I_RESET)
      !O_BORROW_OUT_N |-> ($past(count_next) == `CNT_ZERO &&
                           !$past(I_CLOCKS.count_down_clock));
  endproperty
  a_borrow: assert property (p_borrow) // R11
    else $error("borrow low outside terminal state");

  // Terminal state held with counting enabled and the active clock low
  sequence s_carry_armed;
    (O_COUNT == max_val) && I_CTRL.preset_load_n &&
    !I_CTRL.master_clear && !I_CLOCKS.count_up_clock;
  endsequence
  sequence s_borrow_armed;
    (O_COUNT == `CNT_ZERO) && I_CTRL.preset_load_n &&
    !I_CTRL.master_clear && !I_CLOCKS.count_down_clock;
  endsequence

  property p_carry_low;
    @(posedge I_CLK) disable iff (I_RESET)
      s_carry_armed |=> !O_CARRY_OUT_N;
  endproperty
  a_carry_low: assert property (p_carry_low) // R10
    else $error("carry stayed high at maximum");

  property p_borrow_low;
    @(posedge I_CLK) disable iff (I_RESET)
      s_borrow_armed |=> !O_BORROW_OUT_N;
  endproperty
  a_borrow_low: assert property (p_borrow_low) // R11
    else $error("borrow stayed high at zero");

  property p_carry_release;
    @(posedge I_CLK) disable iff (I_RESET)
      (!O_CARRY_OUT_N && I_CLOCKS.count_up_clock) |=> O_CARRY_OUT_N;
  endproperty
  a_carry_release: assert property (p_carry_release) // R10
    else $error("carry did not follow up clock high");

  property p_borrow_release;
    @(posedge I_CLK) disable iff (I_RESET)
      (!O_BORROW_OUT_N && I_CLOCKS.count_down_clock) |=> O_BORROW_OUT_N;
  endproperty
  a_borrow_release: assert property (p_borrow_release) // R11
    else $error("borrow did not follow down clock high");
endmodule : updown_counter
`default_nettype wire

/* File: common/updown_regs.svh */
// Named constants for the dual clock up/down counter.
// Assumes inclusion by bare name from package and design files.
`ifndef UPDOWN_REGS_SVH
`define UPDOWN_REGS_SVH
`define CNT_W 4
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define CNT_MAX_DEC 4'h9
`define CNT_MAX_BIN 4'hf
`endif

/* File: common/updown_pkg.sv */
// Types shared by the up/down counter design files.
// Assumes updown_regs.svh is on the include path.
`default_nettype none
`include "updown_regs.svh"
package updown_pkg;
  typedef logic [`CNT_W-1:0] count_t;
  typedef struct packed {
    logic count_up_clock;
    logic count_down_clock;
  } clocks_t;
  typedef struct packed {
    logic preset_load_n;
    logic master_clear;
    count_t preset;
  } ctrl_t;
  typedef enum logic [2:0] {
    ST_CLEAR = 3'b001,
    ST_LOAD = 3'b010,
    ST_COUNT = 3'b100
  } mode_t;
endpackage : updown_pkg
`default_nettype wire

/* File: logic/edge_detect.sv */
// Rising and falling edge detector for a sampled count clock level.
// Assumes the input is already synchronous to I_CLK.
`default_nettype none
module edge_detect (
  input wire logic clk,
  input wire logic reset,
  input wire logic level,
  output logic rise,
  output logic fall,
  output logic last
);
  logic last_reg;
  // Resets high so a clock held high at reset gives no false edge
  always_ff @(posedge clk) begin
    if (reset) begin
      last_reg <= 1'b1;
    end else begin
      last_reg <= level;
    end
  end
  assign rise = level & ~last_reg;
  assign fall = ~level & last_reg;
  assign last = last_reg;
endmodule : edge_detect
`default_nettype wire

/* File: tb/next_stage.sv */
// Model of the next cascaded stage, clocked by carry and borrow.
// Assumes both inputs are registered levels on the system clock.
`default_nettype none
module next_stage
  import updown_pkg::*;
(
  // Clock
  input wire logic clk,
  // Cascade inputs
  input wire logic carry_n,
  input wire logic borrow_n,
  // Counts seen
  output count_t ups,
  output count_t downs
);
  timeunit 1ns;
  timeprecision 100ps;
  logic carry_last;
  logic borrow_last;
  initial begin
    ups = 4'h0;
    downs = 4'h0;
    carry_last = 1'b1;
    borrow_last = 1'b1;
  end
  // Rising edge of carry or borrow clocks this stage
  always @(posedge clk) begin
    if (!carry_last && carry_n) ups <= ups + 4'h1;
    if (!borrow_last && borrow_n) downs <= downs + 4'h1;
    carry_last <= carry_n;
    borrow_last <= borrow_n;
  end
endmodule : next_stage
`default_nettype wire

/* File: tb/up_down_counter_dual_clock_test.sv */
// Self-checking bench for the counter, decade and binary builds.
// Assumes the package and next_stage model are compiled first.
`default_nettype none
module up_down_counter_dual_clock_test
  import updown_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic reset;
  clocks_t clocks;
  ctrl_t ctrl;
  count_t count;
  logic carry_n;
  logic borrow_n;
  count_t ups;
  count_t downs;
  count_t seen;
  count_t count_bin;
  logic carry_bin_n;
  logic borrow_bin_n;
  int fail_count;
  int checks;
  int cycles;
  updown_counter #(.DECADE(1'b1)) updown_counter_i (
    .I_CLK(clk), .I_RESET(reset), .I_CLOCKS(clocks), .I_CTRL(ctrl),
    .O_COUNT(count), .O_CARRY_OUT_N(carry_n), .O_BORROW_OUT_N(borrow_n));
  // Binary build shares the stimulus so both wrap points are exercised
  updown_counter #(.DECADE(1'b0)) updown_counter_bin_i (
    .I_CLK(clk), .I_RESET(reset), .I_CLOCKS(clocks), .I_CTRL(ctrl),
    .O_COUNT(count_bin), .O_CARRY_OUT_N(carry_bin_n),
    .O_BORROW_OUT_N(borrow_bin_n));
  next_stage next_stage_i (.clk(clk), .carry_n(carry_n),
    .borrow_n(borrow_n), .ups(ups), .downs(downs));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input count_t got, input count_t exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Other clock stays high; direction changes only while both are high
  task automatic pulse(input logic up);
    if (up) clocks.count_up_clock = 1'b0;
    else clocks.count_down_clock = 1'b0;
    tick(2);
    clocks = 2'b11;
    tick(3);
  endtask : pulse
  task automatic load(input count_t v);
    ctrl.preset = v;
    ctrl.preset_load_n = 1'b0;
    tick(2);
    ctrl.preset_load_n = 1'b1;
    tick(2);
  endtask : load
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic test_count;
    check(count, 4'h0);
    check({3'h0, borrow_n}, 4'h1);
    for (int i = 1; i <= 10; i++) begin
      pulse(1'b1);
      check(count, count_t'(i % 10));
      check(count_bin, count_t'(i));
    end
    pulse(1'b0);
    check(count, 4'h9);
    check(count_bin, 4'h9);
    pulse(1'b0);
    check(count, 4'h8);
    check(count_bin, 4'h8);
  endtask : test_count
  task automatic test_load_clear;
    ctrl.preset = 4'h5;
    ctrl.preset_load_n = 1'b0;
    pulse(1'b1);
    check(count, 4'h5);
    clocks.count_up_clock = 1'b0;
    tick(2);
    ctrl.preset_load_n = 1'b1;
    tick(2);
    clocks.count_up_clock = 1'b1;
    tick(3);
    check(count, 4'h6);
    check(count_bin, 4'h6);
    ctrl = '{1'b0, 1'b1, 4'h7};
    pulse(1'b0);
    check(count, 4'h0);
    check(count_bin, 4'h0);
    ctrl = '{1'b1, 1'b0, 4'h0};
    tick(2);
    check(count, 4'h0);
  endtask : test_load_clear
  task automatic test_cascade;
    load(4'h9);
    seen = ups;
    clocks.count_up_clock = 1'b0;
    tick(3);
    check({3'h0, carry_n}, 4'h0);
    clocks.count_up_clock = 1'b1;
    tick(3);
    check({3'h0, carry_n}, 4'h1);
    check(count, 4'h0);
    check(count_bin, 4'ha);
    check(ups, seen + 4'h1);
    seen = downs;
    clocks.count_down_clock = 1'b0;
    tick(3);
    check({3'h0, borrow_n}, 4'h0);
    check({3'h0, carry_n}, 4'h1);
    clocks.count_down_clock = 1'b1;
    tick(3);
    check(count, 4'h9);
    check(downs, seen + 4'h1);
    // Up edge while the down clock is low must not count
    clocks = 2'b00;
    tick(2);
    clocks.count_up_clock = 1'b1;
    tick(3);
    check(count, 4'h9);
    clocks.count_down_clock = 1'b1;
    tick(3);
    check(count, 4'h8);
    check(count_bin, 4'h8);
  endtask : test_cascade
  // Binary maximum, decade above-range wrap and a reset in mid-run
  task automatic test_binary;
    load(4'hf);
    check(count, 4'hf);
    check(count_bin, 4'hf);
    clocks.count_up_clock = 1'b0;
    tick(2);
    check({3'h0, carry_bin_n}, 4'h0);
    check({3'h0, carry_n}, 4'h1);
    clocks = 2'b11;
    tick(3);
    check({3'h0, carry_bin_n}, 4'h1);
    check(count, 4'h0);
    check(count_bin, 4'h0);
    clocks.count_down_clock = 1'b0;
    tick(2);
    check({3'h0, borrow_n}, 4'h0);
    check({3'h0, borrow_bin_n}, 4'h0);
    clocks = 2'b11;
    tick(3);
    check(count, 4'h9);
    check(count_bin, 4'hf);
    check({3'h0, borrow_bin_n}, 4'h1);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(1);
    check(count, 4'h0);
    check(count_bin, 4'h0);
    check({3'h0, borrow_bin_n}, 4'h1);
    check({3'h0, carry_bin_n}, 4'h1);
  endtask : test_binary
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    reset = 1'b1;
    clocks = 2'b11;
    ctrl = '{1'b1, 1'b0, 4'h0};
    fail_count = 0;
    checks = 0;
    cycles = 0;
    tick(5);
    reset = 1'b0;
    tick(1);
    test_count();
    test_load_clear();
    test_cascade();
    test_binary();
    give_verdict();
  end
endmodule : up_down_counter_dual_clock_test
`default_nettype wire
